// file: pkg/lcig_pkg.sv
// Package with register map and field layout of the logic cell input gating stage
package lcig_pkg;
  localparam logic [11:0] LCIG_SEL_OFFSET = 12'h000;
  localparam logic [11:0] LCIG_GATE_OFFSET = 12'h004;
  localparam logic [15:0] LCIG_SEL_RESET = 16'h0000;
  localparam logic [15:0] LCIG_GATE_RESET = 16'h0000;
  localparam logic [15:0] LCIG_SEL_MASK = 16'h7777;
  localparam int LCIG_SRC_ONE_LSB = 0;
  localparam int LCIG_SRC_TWO_LSB = 4;
  localparam int LCIG_SRC_THREE_LSB = 8;
  localparam int LCIG_SRC_FOUR_LSB = 12;
  localparam int LCIG_GATE_THREE_LSB = 0;
  localparam int LCIG_GATE_FOUR_LSB = 8;
  localparam int LCIG_SEL_WIDTH = 3;
  localparam int LCIG_NUM_SRC = 4;
endpackage

// file: hdl/lcig_gate_combine.sv
// Polarity enable and OR of four data sources into one gate input
`timescale 1ns/10ps
module lcig_gate_combine
(
  input wire logic [3:0] src,
  input wire logic [7:0] en,
  output logic gate
);
  // Field pairs per source k: bit 2k is inverted enable, bit 2k+1 true enable
  wire [3:0] true_en = {en[7], en[5], en[3], en[1]};
  wire [3:0] inv_en = {en[6], en[4], en[2], en[0]};
  wire [3:0] true_terms = src & true_en;
  wire [3:0] inv_terms = ~src & inv_en;
  // No enabled term leaves the gate input low
  assign gate = |true_terms | |inv_terms;
endmodule // lcig_gate_combine

// file: hdl/lcig_top.sv
// APB-reachable input selection and gate 3/4 polarity enable stage
//
// Operation
// RL1: Bits 2:0 select source one signal
// RL2: Bits 6:4 select source two signal
// RL3: Bits 10:8 select source three signal
// RL4: Bits 14:12 select source four signal
// RL5: Select bits 15,11,7,3 read zero
// RL6: Gate four true enables, bits 15,13,11,9
// RL7: Gate four inverted enables, bits 14,12,10,8
// RL8: Gate three true enables, bits 7,5,3,1
// RL9: Gate three inverted enables, bits 6,4,2,0
// RL10: Cleared enable blocks that polarity
// RL11: Eight-entry input vector per mux
// RL12: Enabled terms ORed; registers reset zero
//
// The placing of the registers and the APB interface to the registers are this design's own decisions.
`timescale 1ns/10ps
module lcig_top
  import lcig_pkg::*;
#(
  parameter int MUX_INPUTS = 8
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [MUX_INPUTS-1:0] mux_one_in,
  input wire logic [MUX_INPUTS-1:0] mux_two_in,
  input wire logic [MUX_INPUTS-1:0] mux_three_in,
  input wire logic [MUX_INPUTS-1:0] mux_four_in,
  output logic [3:0] data_src,
  output logic gate_three,
  output logic gate_four
);
  logic [15:0] logic_cell_input_select;
  logic [15:0] gate_three_four_polarity_enables;

  wire access = psel && penable;
  wire hit_sel = paddr == LCIG_SEL_OFFSET;
  wire hit_gate = paddr == LCIG_GATE_OFFSET;
  wire unmapped = !(hit_sel || hit_gate);
  wire wr_sel = access && pwrite && hit_sel;
  wire wr_gate = access && pwrite && hit_gate;
  wire [15:0] lane_mask = {{8{pstrb[1]}}, {8{pstrb[0]}}};

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] wd,
                                        input logic [15:0] m);
    merge = (old & ~m) | (wd & m);
  endfunction

  // Reserved select bits dropped on write so they always read zero
  wire [15:0] next_select = merge(logic_cell_input_select, pwdata[15:0],
                                  lane_mask) & LCIG_SEL_MASK; // RL5
  wire [15:0] next_enables = merge(gate_three_four_polarity_enables, pwdata[15:0], lane_mask);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      logic_cell_input_select <= LCIG_SEL_RESET; // RL12
      gate_three_four_polarity_enables <= LCIG_GATE_RESET; // RL12
    end
    else
    begin
      if (wr_sel)
        logic_cell_input_select <= next_select;
      if (wr_gate)
        gate_three_four_polarity_enables <= next_enables;
    end
  end

  // Zero-wait slave; unmapped addresses answer with an error
  assign pready = 1'b1;
  assign pslverr = access && unmapped;
  wire [15:0] rd_value = hit_sel ? logic_cell_input_select :
                         hit_gate ? gate_three_four_polarity_enables : 16'h0000;
  assign prdata = {16'h0000, rd_value};

  wire [2:0] source_one_select =
    logic_cell_input_select[LCIG_SRC_ONE_LSB +: LCIG_SEL_WIDTH]; // RL1
  wire [2:0] source_two_select =
    logic_cell_input_select[LCIG_SRC_TWO_LSB +: LCIG_SEL_WIDTH]; // RL2
  wire [2:0] source_three_select =
    logic_cell_input_select[LCIG_SRC_THREE_LSB +: LCIG_SEL_WIDTH]; // RL3
  wire [2:0] source_four_select =
    logic_cell_input_select[LCIG_SRC_FOUR_LSB +: LCIG_SEL_WIDTH]; // RL4

  // Mux outputs registered so data outputs come from flip-flops
  wire [3:0] next_data_src = {mux_four_in[source_four_select],
                              mux_three_in[source_three_select],
                              mux_two_in[source_two_select],
                              mux_one_in[source_one_select]}; // RL11

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      data_src <= 4'h0;
    else
      data_src <= next_data_src;
  end

  wire next_gate_three;
  wire next_gate_four;

  lcig_gate_combine u_gate_three
  (
    .src(data_src),
    .en(gate_three_four_polarity_enables[LCIG_GATE_THREE_LSB +: 8]), // RL8 RL9
    .gate(next_gate_three) // RL10 RL12
  );

  lcig_gate_combine u_gate_four
  (
    .src(data_src),
    .en(gate_three_four_polarity_enables[LCIG_GATE_FOUR_LSB +: 8]), // RL6 RL7
    .gate(next_gate_four) // RL10 RL12
  );

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      gate_three <= 1'b0;
      gate_four <= 1'b0;
    end
    else
    begin
      gate_three <= next_gate_three;
      gate_four <= next_gate_four;
    end
  end
endmodule // lcig_top

// file: tb/lcig_properties.sv
// Port checker for the input gating stage
`timescale 1ns/10ps
module lcig_properties
  import lcig_pkg::*;
#(parameter int MUX_INPUTS = 8)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic [MUX_INPUTS-1:0] mux_one_in,
  input wire logic [3:0] data_src,
  input wire logic gate_three,
  input wire logic gate_four
);
  // Only full low-half writes, so a partial strobe never fires these
  wire wr = psel && penable && pwrite && pstrb[1:0] == 2'b11;
  wire ws = wr && paddr == LCIG_SEL_OFFSET;
  wire wg = wr && paddr == LCIG_GATE_OFFSET;
  wire [15:0] d = pwdata[15:0];
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_reset_clear: assert property ($rose(rst_n) |->
    !data_src && !gate_three && !gate_four) else $error("outputs set after reset");
  chk_sel_rsvd: assert property (psel && penable && !pwrite && paddr == LCIG_SEL_OFFSET |->
    !(prdata & 32'h0000_8888)) else $error("reserved select bit set");
  chk_src_low: assert property (ws && !d[2:0] |->
    ##2 data_src[0] == $past(mux_one_in[0])) else $error("source one low index");
  chk_src_high: assert property (ws && &d[2:0] |->
    ##2 data_src[0] == $past(mux_one_in[7])) else $error("source one high index");
  chk_gate_none: assert property (wg && !d |->
    ##2 !gate_three && !gate_four) else $error("gate on with no enables");
  chk_gate_true: assert property (wg && d == 16'h0202 |->
    ##2 gate_three == $past(data_src[0]) && gate_four == gate_three) else $error("true path");
  chk_gate_inv: assert property (wg && d == 16'h0101 |->
    ##2 gate_three != $past(data_src[0]) && gate_four == gate_three) else $error("inverted path");
  chk_gate_or: assert property (wg && &d |->
    ##2 gate_three && gate_four) else $error("gate not ored");
  cover property (ws);
  cover property (wg);
  cover property (psel && penable && !pwrite);
endmodule // lcig_properties

// file: tb/test_lcig_top.sv
// Self-checking bench for the input gating stage
`timescale 1ns/10ps
module test_lcig_top;
  import lcig_pkg::*;
  logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, er;
  logic gate_three, gate_four;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [3:0] pstrb = 4'hf, data_src;
  logic [7:0] mux_one_in = 8'ha5, mux_two_in = 8'h3c, mux_three_in = 8'h96, mux_four_in = 8'h5a;
  logic [15:0] tbl [4] = '{16'h0000, 16'hffff, 16'h0202, 16'h0101};
  int err_total = 0, n_compared = 0;
  lcig_top dut (.*);
  initial forever #10 clk = ~clk;
  initial
  begin
    #100000;
    err_total++;
    finish_test;
  end
  task automatic chk(input logic [31:0] seen, exp, input string what);
    n_compared++;
    if (seen !== exp)
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    err_total += (seen !== exp);
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [15:0] d);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, 16'h0000, d};
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
    // Idle cycle keeps psel from being driven twice in one step
    @(posedge clk);
  endtask
  function automatic logic exp_g(logic [7:0] e, logic [3:0] s);
    return |({e[7], e[5], e[3], e[1]} & s) || |({e[6], e[4], e[2], e[0]} & ~s);
  endfunction
  task automatic t_reg;
    apb(0, LCIG_GATE_OFFSET, 0);
    chk(rd, 0, "gate reg reset");
    apb(1, 12'h008, 16'hffff);
    chk(er, 1, "unmapped error");
    apb(1, LCIG_SEL_OFFSET, 16'hffff);
    apb(0, LCIG_SEL_OFFSET, 0);
    chk(rd, 32'h0000_7777, "select readback");
    $display("register test done");
  endtask
  task automatic t_sel;
    logic [3:0] ex;
    for (int i = 0; i < 8; i++)
    begin
      apb(1, LCIG_SEL_OFFSET, {4{1'b0, i[2:0]}});
      @(posedge clk);
      ex = {mux_four_in[i], mux_three_in[i], mux_two_in[i], mux_one_in[i]};
      chk(data_src, ex, "data_src");
    end
    $display("select test done");
  endtask
  task automatic t_gate;
    logic [15:0] en;
    logic [3:0] s;
    s = {mux_four_in[0], mux_three_in[0], mux_two_in[0], mux_one_in[0]};
    apb(1, LCIG_SEL_OFFSET, 0);
    for (int i = 0; i < 20; i++)
    begin
      en = i < 16 ? 16'h0001 << i : tbl[i - 16];
      apb(1, LCIG_GATE_OFFSET, en);
      @(posedge clk);
      chk(gate_three, exp_g(en[7:0], s), "gate_three");
      chk(gate_four, exp_g(en[15:8], s), "gate_four");
    end
    $display("gate test done");
  endtask
  // Mid-run reset: outputs clear while held, gate register reads zero after
  task automatic t_rst;
    apb(1, LCIG_GATE_OFFSET, 16'hffff);
    rst_n <= 0;
    @(posedge clk);
    chk(data_src, 0, "data_src in reset");
    chk({gate_three, gate_four}, 0, "gates in reset");
    rst_n <= 1;
    @(posedge clk);
    apb(0, LCIG_GATE_OFFSET, 0);
    chk(rd, 0, "gate reg after reset");
    apb(0, 12'h00c, 0);
    chk(rd, 0, "unmapped read data");
    chk(er, 1, "unmapped read error");
    $display("reset test done");
  endtask
  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    repeat (20) @(posedge clk);
    rst_n <= 1;
    @(posedge clk);
    t_reg;
    t_sel;
    t_gate;
    t_rst;
    finish_test;
  end
endmodule // test_lcig_top
bind lcig_top lcig_properties #(.MUX_INPUTS(MUX_INPUTS)) u_chk (.*);
